// *** rtl/pid_pkg.sv ***
package pid_pkg;

	// fixed point: percentages in 0.1 % steps, 1000 = full scale
	localparam int VAL_W = 16;
	localparam int ACC_W = 32;
	localparam logic signed [15:0] FULL_SCALE  = 16'sd1000;
	localparam logic signed [15:0] NEG_FULL    = -16'sd1000;

	// clock and time bases
	localparam int CLK_HZ          = 50_000_000;
	localparam int MS_PER_S        = 1000;
	localparam int TICK_CYCLES     = CLK_HZ / MS_PER_S;     // 1 ms tick
	localparam int TICK_W          = 16;
	localparam int LOSS_TIME_MS    = 1000;                  // 1.0 s default
	localparam int SAMPLE_TIME_MS  = 100;                   // 0.100 s default

	// mode selector codes
	localparam logic [3:0] FREQ_SRC_PID = 4'h7;
	localparam logic [3:0] VOLT_SRC_PID = 4'h6;

	// reset values of settings
	localparam logic signed [15:0] KEYPAD_RST  = 16'sd0;
	localparam logic [15:0] KP_RST             = 16'd180;   // gain x100
	localparam logic [15:0] TI_RST             = 16'd90;    // time in 10 ms
	localparam logic [15:0] TD_RST             = 16'd0;
	localparam logic signed [15:0] UPPER_RST   = 16'sd1000;
	localparam logic signed [15:0] LOWER_RST   = 16'sd0;
	localparam logic [15:0] CTRL_RST           = 16'h0001;
	localparam logic [15:0] LOSS_THR_RST       = 16'd0;

	// control selection digit positions
	localparam int CTRL_HOLD_BIT  = 0;
	localparam int CTRL_DIR_BIT   = 4;
	localparam int CTRL_SCALE_BIT = 8;

	// register offsets
	localparam logic [4:0] R_MODE     = 5'h00;
	localparam logic [4:0] R_REF_SRC  = 5'h01;
	localparam logic [4:0] R_KEYPAD   = 5'h02;
	localparam logic [4:0] R_FB_SRC   = 5'h03;
	localparam logic [4:0] R_POLARITY = 5'h04;
	localparam logic [4:0] R_KP       = 5'h05;
	localparam logic [4:0] R_TI       = 5'h06;
	localparam logic [4:0] R_TD       = 5'h07;
	localparam logic [4:0] R_SAMPLE   = 5'h08;
	localparam logic [4:0] R_UPPER    = 5'h09;
	localparam logic [4:0] R_LOWER    = 5'h0a;
	localparam logic [4:0] R_LOSS_THR = 5'h0b;
	localparam logic [4:0] R_LOSS_TIM = 5'h0c;
	localparam logic [4:0] R_CTRL     = 5'h0d;
	localparam logic [4:0] R_OUT      = 5'h0e;
	localparam logic [4:0] R_STATUS   = 5'h0f;
	localparam logic [4:0] R_MASK     = 5'h10;

	// status bits
	localparam int ST_LOSS   = 0;
	localparam int ST_SAMPLE = 1;
	localparam int ST_LIMIT  = 2;

	typedef struct packed {
		logic [4:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	// fast inputs into the selectors
	typedef struct packed {
		logic signed [15:0] analog_in_one;
		logic signed [15:0] analog_in_two;
		logic signed [15:0] analog_in_three;
		logic signed [15:0] fast_pulse_in_a;
		logic signed [15:0] fast_pulse_in_b;
		logic signed [15:0] multi_step;
		logic signed [15:0] bus_a;
		logic signed [15:0] bus_b;
		logic signed [15:0] bus_c;
		logic signed [15:0] bus_d;
		logic signed [15:0] exp_card;
	} src_t;

	typedef enum logic [1:0] {
		S_IDLE  = 2'b00,
		S_CALC  = 2'b01,
		S_CLAMP = 2'b10
	} pid_state_t;

endpackage

// *** rtl/process_pid_regulator.sv ***
// Overview of operation
// - pid mode when freq 7 or volt 6
// - proportional term is gain times error
// - integral accumulates error scaled by time
// - derivative uses error change, scaled time
// - reference selector codes 0 to 12
// - keypad reference signed percent, default zero
// - feedback selector codes 0 to 10
// - polarity setting inverts output sense
// - output upper limit, default full scale
// - output lower limit, default zero
// - loss detection threshold and time, 1 s
// - hold digit 0 keeps integrating at limits
// - hold digit 1 freezes integral at limits
// - direction digit reverses output
// - scale digit limits by main reference
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module process_pid_regulator #(
	parameter int TICK_CYCLES = pid_pkg::TICK_CYCLES
) (
	input  wire logic               clk,
	input  wire logic               nrst,
	input  wire pid_pkg::reg_req_t  req,
	output logic [15:0]             rdata,
	input  wire pid_pkg::src_t      src,
	input  wire logic [3:0]         freq_cmd_sel,
	input  wire logic [3:0]         volt_chan_sel,
	input  wire logic signed [15:0] main_ref,
	output logic signed [15:0]      pid_out,
	output logic                    pid_active,
	output logic                    fb_lost,
	output logic                    irq
);
	import pid_pkg::*;

	typedef struct packed {
		logic [3:0]         ref_src;
		logic signed [15:0] keypad;
		logic [3:0]         fb_src;
		logic               polarity;
		logic [15:0]        kp;
		logic [15:0]        ti;
		logic [15:0]        td;
		logic [15:0]        sample;
		logic signed [15:0] upper;
		logic signed [15:0] lower;
		logic [15:0]        loss_thr;
		logic [15:0]        loss_tim;
		logic [15:0]        ctrl;
		logic [2:0]         status;
		logic [2:0]         mask;
		logic [15:0]        rdata;
		pid_state_t         state;
		logic signed [31:0] integ;
		logic signed [15:0] err_prev;
		logic signed [15:0] err;
		logic signed [31:0] raw;
		logic signed [15:0] out;
		logic [31:0]        loss_cnt;
		logic               lost;
	} st_t;

	st_t q, d;
	logic tick, fire;
	logic signed [15:0] ref_val, fb_val, hi_lim, lo_lim;
	logic signed [31:0] p_term, i_step, d_term, ref_scaled;
	logic at_limit;
	// settings widened as signed so negative errors divide correctly
	logic signed [31:0] kp_s, ti_s, td_s, smp_s;

	// zero-extended unsigned settings, used as signed operands
	assign kp_s  = $signed({16'h0000, q.kp});
	assign ti_s  = $signed({16'h0000, q.ti});
	assign td_s  = $signed({16'h0000, q.td});
	assign smp_s = $signed({16'h0000, q.sample});

	// sample and millisecond enables
	tick_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
		.clk      (clk),
		.nrst     (nrst),
		.period_ms(q.sample),
		.tick     (tick),
		.fire     (fire)
	);

	// scale a limit by the main reference when asked
	// relative limits follow the main reference in 0.1 % steps
	function automatic logic signed [15:0] scale_lim(input logic signed [15:0] lim,
			input logic rel, input logic signed [15:0] mref);
		logic signed [31:0] prod;
		prod = 32'(lim) * 32'(mref);
		scale_lim = rel ? 16'(prod / 32'sd1000) : lim;
	endfunction

	// reference source selection
	always_comb begin
		unique case (q.ref_src)
			4'h0: ref_val = q.keypad;
			4'h1: ref_val = src.analog_in_one;
			4'h2: ref_val = src.analog_in_two;
			4'h3: ref_val = src.analog_in_three;
			4'h4: ref_val = src.fast_pulse_in_a;
			4'h5: ref_val = src.multi_step;
			4'h6: ref_val = src.bus_a;
			4'h7: ref_val = src.bus_b;
			4'h8: ref_val = src.bus_c;
			4'h9: ref_val = src.fast_pulse_in_b;
			4'ha: ref_val = src.bus_d;
			4'hb: ref_val = src.exp_card;
			default: ref_val = '0; // reserved
		endcase
	end

	// feedback source selection
	always_comb begin
		unique case (q.fb_src)
			4'h0: fb_val = src.analog_in_one;
			4'h1: fb_val = src.analog_in_two;
			4'h2: fb_val = src.analog_in_three;
			4'h3: fb_val = src.fast_pulse_in_a;
			4'h4: fb_val = src.bus_a;
			4'h5: fb_val = src.bus_b;
			4'h6: fb_val = src.bus_c;
			4'h7: fb_val = src.fast_pulse_in_b;
			4'h8: fb_val = src.bus_d;
			4'h9: fb_val = src.exp_card;
			default: fb_val = '0; // reserved
		endcase
	end

	// terms: gain x100, times in 10 ms units, sample in ms
	always_comb begin
		p_term = (kp_s * 32'(q.err)) / 32'sd100;
		if (q.ti == 16'd0) begin
			i_step = '0;
		end else begin
			i_step = (p_term * smp_s) / (ti_s * 32'sd10);
		end
		if (q.td == 16'd0 || q.sample == 16'd0) begin
			d_term = '0;
		end else begin
			d_term = (p_term - (kp_s * 32'(q.err_prev)) / 32'sd100)
				* td_s * 32'sd10 / smp_s;
		end
		hi_lim = scale_lim(q.upper, q.ctrl[CTRL_SCALE_BIT], main_ref);
		lo_lim = scale_lim(q.lower, q.ctrl[CTRL_SCALE_BIT], main_ref);
		ref_scaled = q.raw;
		if (q.polarity) begin
			ref_scaled = -q.raw;
		end
		if (q.ctrl[CTRL_DIR_BIT]) begin
			ref_scaled = -ref_scaled;
		end
		at_limit = (q.out >= hi_lim) || (q.out <= lo_lim);
	end

	// register access, pid sequencing and loss detection
	always_comb begin
		d = q;
		d.rdata = '0;
		// keypad, upper and lower are clamped on write
		// status is write-one-to-clear; hardware sets below win
		if (req.wr) begin
			unique case (req.addr)
				R_REF_SRC:  d.ref_src = req.wdata[3:0];
				R_KEYPAD: begin
					if ($signed(req.wdata) > FULL_SCALE) begin
						d.keypad = FULL_SCALE;
					end else if ($signed(req.wdata) < NEG_FULL) begin
						d.keypad = NEG_FULL;
					end else begin
						d.keypad = req.wdata;
					end
				end
				R_FB_SRC:   d.fb_src = req.wdata[3:0];
				R_POLARITY: d.polarity = req.wdata[0];
				R_KP:       d.kp = req.wdata;
				R_TI:       d.ti = req.wdata;
				R_TD:       d.td = req.wdata;
				R_SAMPLE:   d.sample = req.wdata;
				R_UPPER: begin
					if ($signed(req.wdata) > FULL_SCALE) begin
						d.upper = FULL_SCALE;
					end else if ($signed(req.wdata) < q.lower) begin
						d.upper = q.lower;
					end else begin
						d.upper = req.wdata;
					end
				end
				R_LOWER: begin
					if ($signed(req.wdata) < NEG_FULL) begin
						d.lower = NEG_FULL;
					end else if ($signed(req.wdata) > q.upper) begin
						d.lower = q.upper;
					end else begin
						d.lower = req.wdata;
					end
				end
				R_LOSS_THR: d.loss_thr = req.wdata;
				R_LOSS_TIM: d.loss_tim = req.wdata;
				// control keeps only the low bit of each digit
				R_CTRL:     d.ctrl = req.wdata & 16'h1111;
				R_STATUS:   d.status = q.status & ~req.wdata[2:0];
				R_MASK:     d.mask = req.wdata[2:0];
				default:    ;
			endcase
		end
		// read data live one cycle, zero otherwise
		if (req.rd) begin
			unique case (req.addr)
				R_MODE:     d.rdata = {15'h0, pid_active};
				R_REF_SRC:  d.rdata = {12'h0, q.ref_src};
				R_KEYPAD:   d.rdata = q.keypad;
				R_FB_SRC:   d.rdata = {12'h0, q.fb_src};
				R_POLARITY: d.rdata = {15'h0, q.polarity};
				R_KP:       d.rdata = q.kp;
				R_TI:       d.rdata = q.ti;
				R_TD:       d.rdata = q.td;
				R_SAMPLE:   d.rdata = q.sample;
				R_UPPER:    d.rdata = q.upper;
				R_LOWER:    d.rdata = q.lower;
				R_LOSS_THR: d.rdata = q.loss_thr;
				R_LOSS_TIM: d.rdata = q.loss_tim;
				R_CTRL:     d.rdata = q.ctrl;
				R_OUT:      d.rdata = q.out;
				R_STATUS:   d.rdata = {13'h0, q.status};
				R_MASK:     d.rdata = {13'h0, q.mask};
				default:    d.rdata = '0;
			endcase
		end

		// regulator sequence
		unique case (q.state)
			S_IDLE: begin
				// error latched once per sample; sources read live
				if (fire && pid_active) begin
					d.err = 16'(ref_val - fb_val);
					d.state = S_CALC;
				end
			end
			S_CALC: begin
				// anti-windup: hold digit freezes the sum at a limit
				if (!(q.ctrl[CTRL_HOLD_BIT] && at_limit)) begin
					d.integ = q.integ + i_step;
				end
				d.raw = p_term + d.integ + d_term;
				// previous error kept for the next rate term
				d.err_prev = q.err;
				d.state = S_CLAMP;
			end
			S_CLAMP: begin
				// polarity and direction applied before the clamp
				if (ref_scaled > 32'(hi_lim)) begin
					d.out = hi_lim;
				end else if (ref_scaled < 32'(lo_lim)) begin
					d.out = lo_lim;
				end else begin
					d.out = 16'(ref_scaled);
				end
				// limit flag lets software see saturation
				d.status[ST_SAMPLE] = 1'b1;
				if (d.out == hi_lim || d.out == lo_lim) begin
					d.status[ST_LIMIT] = 1'b1;
				end
				d.state = S_IDLE;
			end
			default: d.state = S_IDLE;
		endcase

		// feedback loss: loss_tim in 0.1 s units, counted in ms ticks
		if (q.loss_thr == 16'd0 || fb_val >= $signed(q.loss_thr)) begin
			d.loss_cnt = '0;
			d.lost = 1'b0;
		end else if (tick) begin
			if (q.loss_cnt >= 32'(q.loss_tim) * 32'd100) begin
				d.lost = 1'b1;
				d.status[ST_LOSS] = 1'b1;
			end else begin
				// counter stops at the limit so it cannot wrap
				d.loss_cnt = q.loss_cnt + 32'd1;
			end
		end
	end

	// synchronous reset loads the default settings
	always_ff @(posedge clk) begin
		if (!nrst) begin
			q <= '{ref_src: '0, keypad: KEYPAD_RST, fb_src: '0, polarity: 1'b0,
				kp: KP_RST, ti: TI_RST, td: TD_RST, sample: 16'(SAMPLE_TIME_MS),
				upper: UPPER_RST, lower: LOWER_RST, loss_thr: LOSS_THR_RST,
				loss_tim: 16'(LOSS_TIME_MS / 100), ctrl: CTRL_RST, status: '0,
				mask: '0, rdata: '0, state: S_IDLE, integ: '0, err_prev: '0,
				err: '0, raw: '0, out: '0, loss_cnt: '0, lost: 1'b0};
		end else begin
			q <= d;
		end
	end

	// mode decode is combinational from the two selectors
	assign pid_active = (freq_cmd_sel == FREQ_SRC_PID)
		|| (volt_chan_sel == VOLT_SRC_PID);
	assign rdata   = q.rdata;
	assign pid_out = q.out;
	assign fb_lost = q.lost;
	assign irq     = |(q.status & q.mask);
endmodule
`default_nettype wire

// *** rtl/tick_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
// one-cycle enable every n ticks of the 1 ms base
module tick_timer #(
	parameter int TICK_CYCLES = pid_pkg::TICK_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [15:0] period_ms,
	output logic             tick,
	output logic             fire
);
	import pid_pkg::*;

	typedef struct packed {
		logic [TICK_W-1:0] pre;
		logic [15:0]       cnt;
		logic              tick;
		logic              fire;
	} tt_t;

	tt_t q, d;

	// prescaler then period counter; a zero period fires every tick
	always_comb begin
		d = q;
		d.tick = 1'b0;
		d.fire = 1'b0;
		if (q.pre == TICK_W'(TICK_CYCLES - 1)) begin
			d.pre = '0;
			d.tick = 1'b1;
			if (q.cnt + 16'd1 >= period_ms) begin
				d.cnt = '0;
				d.fire = 1'b1;
			end else begin
				d.cnt = q.cnt + 16'd1;
			end
		end else begin
			d.pre = q.pre + TICK_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick = q.tick;
	assign fire = q.fire;
endmodule
`default_nettype wire

// *** verif/pid_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module pid_checker (
	input  wire logic               clk,
	input  wire logic               nrst,
	input  wire pid_pkg::reg_req_t  req,
	input  wire logic [15:0]        rdata,
	input  wire logic [3:0]         freq_cmd_sel,
	input  wire logic [3:0]         volt_chan_sel,
	input  wire logic signed [15:0] pid_out,
	input  wire logic               pid_active,
	input  wire logic               fb_lost,
	input  wire logic               irq
);
	import pid_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// mode follows the two selectors
	a_mode_select: assert property (pid_active == (freq_cmd_sel == FREQ_SRC_PID ||
		volt_chan_sel == VOLT_SRC_PID)) else $error("mode flag wrong");
	// read data only in the cycle after a read
	a_read_idle: assert property (!$past(req.rd) |-> rdata == 16'h0000)
		else $error("read data outside slot");
	a_unmapped_zero: assert property (req.rd && req.addr > R_MASK |=> rdata == 16'h0000)
		else $error("unmapped read not zero");
	// output never leaves full scale
	a_out_range: assert property (pid_out <= FULL_SCALE && pid_out >= NEG_FULL)
		else $error("output beyond full scale");
	// no sampling while inactive
	a_idle_hold: assert property ((!pid_active)[*4] |-> $stable(pid_out))
		else $error("output moved while inactive");
	a_reset_clear: assert property (disable iff (1'b0) !nrst |=> pid_out == 16'sd0 &&
		!fb_lost && !irq && rdata == 16'h0000) else $error("reset state wrong");
	a_mask_quiet: assert property (req.wr && req.addr == R_MASK && req.wdata == 16'h0000
		|-> ##[1:2] !irq) else $error("irq with mask clear");
	// zero threshold disables loss detection
	a_lost_off: assert property (req.wr && req.addr == R_LOSS_THR && req.wdata == 16'h0000
		|-> ##[1:3] !fb_lost) else $error("loss stays with zero threshold");

	c_out_step: cover property (pid_active && $changed(pid_out));
	c_lost: cover property ($rose(fb_lost));
	c_irq: cover property ($rose(irq));
endmodule
bind process_pid_regulator pid_checker chk (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata),
	.freq_cmd_sel(freq_cmd_sel), .volt_chan_sel(volt_chan_sel), .pid_out(pid_out),
	.pid_active(pid_active), .fb_lost(fb_lost), .irq(irq));
`default_nettype wire

// *** verif/tb_process_pid_regulator.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_process_pid_regulator;
	import pid_pkg::*;
	logic               clk;
	logic               nrst;
	reg_req_t           req;
	logic [15:0]        rdata;
	src_t               src;
	logic [3:0]         freq_cmd_sel;
	logic [3:0]         volt_chan_sel;
	logic signed [15:0] main_ref;
	logic signed [15:0] pid_out;
	logic               pid_active;
	logic               fb_lost;
	logic               irq;
	int                 n_fail;
	int                 compares;
	int                 i;
	logic [15:0]        rst_v [1:13] = '{0, 0, 0, 0, 16'h00b4, 16'h005a, 0, 16'h0064,
		16'h03e8, 0, 0, 16'h000a, 16'h0001};
	logic signed [15:0] ref_v [0:12] = '{100, 110, 120, 130, 140, 160, 170, 180, 190, 150,
		200, 210, 0};
	logic signed [15:0] fb_v [0:10] = '{110, 120, 130, 140, 170, 180, 190, 150, 200, 210, 0};

	process_pid_regulator #(.TICK_CYCLES(10)) dut (.clk(clk), .nrst(nrst), .req(req),
		.rdata(rdata), .src(src), .freq_cmd_sel(freq_cmd_sel), .volt_chan_sel(volt_chan_sel),
		.main_ref(main_ref), .pid_out(pid_out), .pid_active(pid_active), .fb_lost(fb_lost),
		.irq(irq));

	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	// data sampled in the single cycle after the strobe
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge clk);
		req <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		chk("rdata", e, rdata);
	endtask

	// let several 10-cycle samples settle the output
	task automatic out(input logic signed [15:0] e);
		repeat (40) @(posedge clk);
		chk("pid_out", e, pid_out);
	endtask

	task automatic complete_run;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		complete_run;
	end

	initial begin
		nrst = 1'b0;
		req = '0;
		src = '{110, 120, 130, 140, 150, 160, 170, 180, 190, 200, 210};
		freq_cmd_sel = 4'h0;
		volt_chan_sel = 4'h0;
		main_ref = 16'sd0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		for (i = 1; i < 14; i++) rd(5'(i), rst_v[i]);
		rd(R_MASK, 16'h0000);
		rd(5'h1f, 16'h0000);
		wr(R_KEYPAD, 16'h07d0);
		rd(R_KEYPAD, 16'h03e8);
		$display("test registers done");
		wr(R_KP, 16'h0064);
		wr(R_TI, 16'h0000);
		wr(R_SAMPLE, 16'h0001);
		wr(R_LOWER, 16'hfc18);
		wr(R_KEYPAD, 16'h0064);
		wr(R_FB_SRC, 16'h000a);
		freq_cmd_sel <= 4'h7;
		for (i = 0; i < 13; i++) begin
			wr(R_REF_SRC, 16'(i));
			out(ref_v[i]);
		end
		wr(R_REF_SRC, 16'h0000);
		wr(R_KEYPAD, 16'h01f4);
		for (i = 0; i < 11; i++) begin
			wr(R_FB_SRC, 16'(i));
			out(16'sd500 - fb_v[i]);
		end
		$display("test sources done");
		wr(R_FB_SRC, 16'h000a);
		wr(R_POLARITY, 16'h0001);
		out(-16'sd500);
		wr(R_CTRL, 16'h0011);
		out(16'sd500);
		wr(R_CTRL, 16'h0001);
		wr(R_LOWER, 16'h0000);
		out(16'sd0);
		wr(R_POLARITY, 16'h0000);
		wr(R_UPPER, 16'h012c);
		out(16'sd300);
		wr(R_MASK, 16'h0004);
		#1;
		chk("irq", 1'b1, irq);
		freq_cmd_sel <= 4'h0;
		volt_chan_sel <= 4'h6;
		out(16'sd300);
		chk("pid_active", 1'b1, pid_active);
		volt_chan_sel <= 4'h0;
		repeat (10) @(posedge clk);
		chk("pid_active", 1'b0, pid_active);
		wr(R_STATUS, 16'h0007);
		rd(R_STATUS, 16'h0000);
		chk("irq", 1'b0, irq);
		$display("test limits done");
		wr(R_UPPER, 16'h03e8);
		wr(R_CTRL, 16'h0000);
		wr(R_TI, 16'h000a);
		freq_cmd_sel <= 4'h7;
		repeat (1500) @(posedge clk);
		out(16'sd1000);
		$display("test integral done");
		wr(R_FB_SRC, 16'h0000);
		wr(R_MASK, 16'h0001);
		wr(R_LOSS_TIM, 16'h0001);
		wr(R_LOSS_THR, 16'h00c8);
		freq_cmd_sel <= 4'h7;
		repeat (900) @(posedge clk);
		chk("fb_lost", 1'b0, fb_lost);
		for (i = 0; i < 300 && fb_lost !== 1'b1; i++) @(posedge clk);
		#1;
		chk("fb_lost", 1'b1, fb_lost);
		chk("irq", 1'b1, irq);
		wr(R_LOSS_THR, 16'h0000);
		repeat (4) @(posedge clk);
		chk("fb_lost", 1'b0, fb_lost);
		$display("test loss done");
		complete_run;
	end
endmodule
`default_nettype wire
